// file: rtl/rtcc_map.svh
// register offsets, field ranges, reset values and counter limits of the calendar block
// assumes inclusion by bare name from the package and the design files
`ifndef RTCC_MAP_SVH
`define RTCC_MAP_SVH

`define RTCC_ADDR_W 8
`define RTCC_OFS_TIME 8'h00
`define RTCC_OFS_DATE 8'h04
`define RTCC_OFS_CTRL 8'h08
`define RTCC_OFS_IRQ_STATUS 8'h0C
`define RTCC_OFS_IRQ_MASK 8'h10
`define RTCC_OFS_CONFIG 8'h14

`define RTCC_TIME_PM 22
`define RTCC_TIME_HT 21:20
`define RTCC_TIME_HU 19:16
`define RTCC_TIME_MT 14:12
`define RTCC_TIME_MU 11:8
`define RTCC_TIME_ST 6:4
`define RTCC_TIME_SU 3:0

`define RTCC_DATE_YT 23:20
`define RTCC_DATE_YU 19:16
`define RTCC_DATE_WD 15:13
`define RTCC_DATE_MT 12
`define RTCC_DATE_MU 11:8
`define RTCC_DATE_DT 5:4
`define RTCC_DATE_DU 3:0

`define RTCC_CTRL_CALIBRATION_OUTPUT_ENABLE 23
`define RTCC_CTRL_SRC 22:21
`define RTCC_CTRL_POL 20
`define RTCC_CTRL_RATE 19
`define RTCC_CTRL_DST 18
`define RTCC_CTRL_SUB 17
`define RTCC_CTRL_ADD 16

`define RTCC_CFG_12H 0
`define RTCC_IRQ_W 3
`define RTCC_IRQ_SECOND 0
`define RTCC_IRQ_DAY 1
`define RTCC_IRQ_ADJUST 2

`define RTCC_RST_TIME 32'h00000000
`define RTCC_RST_DAY 8'h01
`define RTCC_RST_MONTH 8'h01
`define RTCC_RST_YEAR 8'h00
`define RTCC_RST_WEEKDAY 3'h1
`define RTCC_RST_CTRL 6'h00

`define RTCC_ASYNC_PRESCALER 7'h7F
`define RTCC_SYNC_PRESCALER 8'hFF
`define RTCC_APRE_MSB 6
`define RTCC_SPRE_MSB 7

`define RTCC_BCD_ZERO 8'h00
`define RTCC_BCD_ONE 8'h01
`define RTCC_BCD_NINE 4'h9
`define RTCC_SEC_MAX 8'h59
`define RTCC_MIN_MAX 8'h59
`define RTCC_MONTH_MAX 8'h12
`define RTCC_YEAR_MAX 8'h99
`define RTCC_HOUR24_MAX 8'h23
`define RTCC_HOUR12_MAX 8'h12
`define RTCC_HOUR12_LAST 8'h11
`define RTCC_WEEKDAY_LAST 3'h7
`define RTCC_WEEKDAY_NONE 3'h0

`endif

// file: rtl/rtcc_pkg.sv
// types and BCD helpers shared by the calendar block
// assumes the map header sits beside it
`include "rtcc_map.svh"
`default_nettype none
package rtcc_pkg;

   typedef enum logic [1:0] {
      RTCC_SRC_OFF,
      RTCC_SRC_ALARM_A,
      RTCC_SRC_ALARM_B,
      RTCC_SRC_WAKEUP
   } rtcc_source_type;

   typedef struct packed {
      logic calibration_output_enable;
      rtcc_source_type event_output_source;
      logic event_output_polarity;
      logic calibration_rate_select;
      logic daylight_saving_flag;
   } rtcc_ctrl_type;

   typedef struct packed {
      logic [7:0] year;
      logic [2:0] weekday;
      logic [7:0] month;
      logic [7:0] day;
   } rtcc_date_type;

   typedef struct packed {
      logic alarm_a;
      logic alarm_b;
      logic wakeup;
   } rtcc_event_type;

   function automatic logic [7:0] rtcc_bcd_inc(input logic [7:0] v);
      if (v[3:0] == `RTCC_BCD_NINE) begin
         return {4'(v[7:4] + 4'h1), 4'h0};
      end
      return {v[7:4], 4'(v[3:0] + 4'h1)};
   endfunction

   function automatic logic [7:0] rtcc_bcd_dec(input logic [7:0] v);
      if (v[3:0] == 4'h0) begin
         return {4'(v[7:4] - 4'h1), `RTCC_BCD_NINE};
      end
      return {v[7:4], 4'(v[3:0] - 4'h1)};
   endfunction

endpackage
`default_nettype wire

// file: rtl/rtcc_bcd_pair.sv
// one two-digit BCD counter with load, step and wrap from high back to low
// assumes step and load are single-cycle and load wins over step
`default_nettype none
module rtcc_bcd_pair
   import rtcc_pkg::*;
#(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [7:0] load_value,
   input wire logic step,
   input wire logic [7:0] low,
   input wire logic [7:0] high,
   output logic [7:0] value,
   output logic wrap
);
   logic [7:0] next_value;

   always_comb begin
      wrap = step && (value >= high);
      next_value = value;
      if (load) begin
         next_value = load_value;
      end else if (wrap) begin
         next_value = low;
      end else if (step) begin
         next_value = rtcc_bcd_inc(value);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         value <= RESET_VALUE;
      end else begin
         value <= next_value;
      end
   end
endmodule
`default_nettype wire

// file: rtl/rtcc_top.sv
// calendar time and date counters, upper control fields, event and calibration outputs
// assumes a register master on a plain strobe port and kernel clock sampled on ref_clk
`include "rtcc_map.svh"
`default_nettype none
module rtcc_top
   import rtcc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [`RTCC_ADDR_W-1:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   input wire logic rtc_kernel_clock,
   input wire rtcc_event_type events,
   output logic calibration_out,
   output logic event_out,
   output logic irq
);
   localparam int NPAIR = 5;
   localparam int P_SEC = 0;
   localparam int P_MIN = 1;
   localparam int P_DAY = 2;
   localparam int P_MON = 3;
   localparam int P_YEAR = 4;
   localparam logic [NPAIR*8-1:0] PAIR_RESET =
      {`RTCC_RST_YEAR, `RTCC_RST_MONTH, `RTCC_RST_DAY, `RTCC_BCD_ZERO, `RTCC_BCD_ZERO};

   // address decode shared by every write and read path
   function automatic logic hit(input logic [`RTCC_ADDR_W-1:0] a,
                                input logic [`RTCC_ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction

   function automatic logic [7:0] month_days(input logic [7:0] month, input logic [7:0] year);
      logic leap;
      leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                     : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
      case (month)
         8'h02: month_days = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
         default: month_days = 8'h31;
      endcase
   endfunction

   // ---- kernel clock prescalers
   logic kclk_prev, next_kclk_prev;
   logic [6:0] apre_cnt, next_apre_cnt;
   logic [7:0] spre_cnt, next_spre_cnt;
   logic kclk_edge, apre_tick, sec_tick;

   always_comb begin
      next_kclk_prev = rtc_kernel_clock;
      kclk_edge = rtc_kernel_clock && !kclk_prev;
      apre_tick = kclk_edge && (apre_cnt == 7'h00);
      sec_tick = apre_tick && (spre_cnt == 8'h00);
      next_apre_cnt = apre_cnt;
      next_spre_cnt = spre_cnt;
      if (kclk_edge) begin
         next_apre_cnt = apre_tick ? `RTCC_ASYNC_PRESCALER : 7'(apre_cnt - 7'h1);
      end
      if (apre_tick) begin
         next_spre_cnt = sec_tick ? `RTCC_SYNC_PRESCALER : 8'(spre_cnt - 8'h1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         kclk_prev <= 1'b0;
         apre_cnt <= `RTCC_ASYNC_PRESCALER;
         spre_cnt <= `RTCC_SYNC_PRESCALER;
      end else begin
         kclk_prev <= next_kclk_prev;
         apre_cnt <= next_apre_cnt;
         spre_cnt <= next_spre_cnt;
      end
   end

   // ---- register writes
   logic wr_time, wr_date, wr_ctrl, wr_status, wr_mask, wr_cfg;
   logic add_hour, sub_hour;
   rtcc_ctrl_type ctrl, next_ctrl;
   logic twelve_hour, next_twelve_hour;

   always_comb begin
      wr_time = wr_en && hit(addr, `RTCC_OFS_TIME);
      wr_date = wr_en && hit(addr, `RTCC_OFS_DATE);
      wr_ctrl = wr_en && hit(addr, `RTCC_OFS_CTRL);
      wr_status = wr_en && hit(addr, `RTCC_OFS_IRQ_STATUS);
      wr_mask = wr_en && hit(addr, `RTCC_OFS_IRQ_MASK);
      wr_cfg = wr_en && hit(addr, `RTCC_OFS_CONFIG);
      add_hour = wr_ctrl && wr_data[`RTCC_CTRL_ADD];
      sub_hour = wr_ctrl && wr_data[`RTCC_CTRL_SUB];
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl.calibration_output_enable = wr_data[`RTCC_CTRL_CALIBRATION_OUTPUT_ENABLE];
         next_ctrl.event_output_source = rtcc_source_type'(wr_data[`RTCC_CTRL_SRC]);
         next_ctrl.event_output_polarity = wr_data[`RTCC_CTRL_POL];
         next_ctrl.calibration_rate_select = wr_data[`RTCC_CTRL_RATE];
         next_ctrl.daylight_saving_flag = wr_data[`RTCC_CTRL_DST];
      end
      next_twelve_hour = wr_cfg ? wr_data[`RTCC_CFG_12H] : twelve_hour;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl <= rtcc_ctrl_type'(`RTCC_RST_CTRL);
         twelve_hour <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         twelve_hour <= next_twelve_hour;
      end
   end

   // ---- cascaded BCD counters
   logic [NPAIR-1:0] pair_load, pair_step, pair_wrap;
   logic [7:0] pair_load_value [NPAIR];
   logic [7:0] pair_low [NPAIR];
   logic [7:0] pair_high [NPAIR];
   logic [7:0] pair_value [NPAIR];
   logic [7:0] hour, next_hour;
   logic afternoon_flag, next_afternoon_flag;
   logic [2:0] weekday, next_weekday;
   logic day_carry, hour_adjusted;

   always_comb begin
      pair_load = {{3{wr_date}}, {2{wr_time}}};
      pair_load_value[P_SEC] = {1'b0, wr_data[`RTCC_TIME_ST], wr_data[`RTCC_TIME_SU]};
      pair_load_value[P_MIN] = {1'b0, wr_data[`RTCC_TIME_MT], wr_data[`RTCC_TIME_MU]};
      pair_load_value[P_DAY] = {2'b00, wr_data[`RTCC_DATE_DT], wr_data[`RTCC_DATE_DU]};
      pair_load_value[P_MON] = {3'b000, wr_data[`RTCC_DATE_MT], wr_data[`RTCC_DATE_MU]};
      pair_load_value[P_YEAR] = {wr_data[`RTCC_DATE_YT], wr_data[`RTCC_DATE_YU]};
      pair_low[P_SEC] = `RTCC_BCD_ZERO;
      pair_low[P_MIN] = `RTCC_BCD_ZERO;
      pair_low[P_DAY] = `RTCC_BCD_ONE;
      pair_low[P_MON] = `RTCC_BCD_ONE;
      pair_low[P_YEAR] = `RTCC_BCD_ZERO;
      pair_high[P_SEC] = `RTCC_SEC_MAX;
      pair_high[P_MIN] = `RTCC_MIN_MAX;
      pair_high[P_DAY] = month_days(pair_value[P_MON], pair_value[P_YEAR]);
      pair_high[P_MON] = `RTCC_MONTH_MAX;
      pair_high[P_YEAR] = `RTCC_YEAR_MAX;
      pair_step[P_SEC] = sec_tick && !wr_time;
      pair_step[P_MIN] = pair_wrap[P_SEC];
      pair_step[P_DAY] = day_carry && !wr_date;
      pair_step[P_MON] = pair_wrap[P_DAY];
      pair_step[P_YEAR] = pair_wrap[P_MON];
   end

   genvar g;
   generate
      for (g = 0; g < NPAIR; g++) begin : gen_pair
         rtcc_bcd_pair #(
            .RESET_VALUE(PAIR_RESET[g*8 +: 8])
         ) u_pair (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .load(pair_load[g]),
            .load_value(pair_load_value[g]),
            .step(pair_step[g]),
            .low(pair_low[g]),
            .high(pair_high[g]),
            .value(pair_value[g]),
            .wrap(pair_wrap[g])
         );
      end
   endgenerate

   // hours with twelve-hour handling, hour adjust and weekday
   always_comb begin
      next_hour = hour;
      next_afternoon_flag = afternoon_flag;
      next_weekday = weekday;
      day_carry = 1'b0;
      hour_adjusted = 1'b0;
      if (wr_time) begin
         next_hour = {2'b00, wr_data[`RTCC_TIME_HT], wr_data[`RTCC_TIME_HU]};
         next_afternoon_flag = wr_data[`RTCC_TIME_PM];
      end else if (sub_hour) begin
         if (hour != `RTCC_BCD_ZERO) begin
            hour_adjusted = 1'b1;
            if (twelve_hour && hour == `RTCC_HOUR12_MAX) begin
               next_hour = `RTCC_HOUR12_LAST;
               next_afternoon_flag = !afternoon_flag;
            end else if (twelve_hour && hour == `RTCC_BCD_ONE) begin
               next_hour = `RTCC_HOUR12_MAX;
            end else begin
               next_hour = rtcc_bcd_dec(hour);
            end
         end
      end else if (add_hour || pair_wrap[P_MIN]) begin
         hour_adjusted = add_hour;
         if (twelve_hour) begin
            if (hour == `RTCC_HOUR12_LAST) begin
               next_hour = `RTCC_HOUR12_MAX;
               next_afternoon_flag = !afternoon_flag;
               day_carry = afternoon_flag;
            end else if (hour >= `RTCC_HOUR12_MAX) begin
               next_hour = `RTCC_BCD_ONE;
            end else begin
               next_hour = rtcc_bcd_inc(hour);
            end
         end else if (hour >= `RTCC_HOUR24_MAX) begin
            next_hour = `RTCC_BCD_ZERO;
            day_carry = 1'b1;
         end else begin
            next_hour = rtcc_bcd_inc(hour);
         end
      end
      if (wr_date) begin
         if (wr_data[`RTCC_DATE_WD] != `RTCC_WEEKDAY_NONE) begin
            next_weekday = wr_data[`RTCC_DATE_WD];
         end
      end else if (day_carry) begin
         next_weekday = (weekday == `RTCC_WEEKDAY_LAST) ? 3'h1 : 3'(weekday + 3'h1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         hour <= `RTCC_BCD_ZERO;
         afternoon_flag <= 1'b0;
         weekday <= `RTCC_RST_WEEKDAY;
      end else begin
         hour <= next_hour;
         afternoon_flag <= next_afternoon_flag;
         weekday <= next_weekday;
      end
   end

   // ---- interrupt status and mask
   logic [`RTCC_IRQ_W-1:0] irq_status, next_irq_status, irq_mask, next_irq_mask, irq_set;
   logic next_irq;

   always_comb begin
      irq_set = '0;
      irq_set[`RTCC_IRQ_SECOND] = sec_tick;
      irq_set[`RTCC_IRQ_DAY] = day_carry;
      irq_set[`RTCC_IRQ_ADJUST] = hour_adjusted;
      next_irq_status = irq_status;
      if (wr_status) begin
         next_irq_status = irq_status & ~wr_data[`RTCC_IRQ_W-1:0];
      end
      next_irq_status = next_irq_status | irq_set;
      next_irq_mask = wr_mask ? wr_data[`RTCC_IRQ_W-1:0] : irq_mask;
      next_irq = |(next_irq_status & next_irq_mask);
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irq_status <= '0;
         irq_mask <= '0;
         irq <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         irq <= next_irq;
      end
   end

   // ---- outputs and read path
   rtcc_date_type date_now, date_hold, next_date_hold;
   logic hold_valid, next_hold_valid;
   logic [31:0] next_rd_data;
   logic next_calibration_out, next_event_out, source_active;

   always_comb begin
      date_now = '{year: pair_value[P_YEAR], weekday: weekday,
                   month: pair_value[P_MON], day: pair_value[P_DAY]};
      next_date_hold = date_hold;
      next_hold_valid = hold_valid;
      next_rd_data = '0;
      if (rd_en) begin
         if (hit(addr, `RTCC_OFS_TIME)) begin
            next_rd_data[`RTCC_TIME_PM] = afternoon_flag;
            next_rd_data[`RTCC_TIME_HT] = hour[5:4];
            next_rd_data[`RTCC_TIME_HU] = hour[3:0];
            next_rd_data[`RTCC_TIME_MT] = pair_value[P_MIN][6:4];
            next_rd_data[`RTCC_TIME_MU] = pair_value[P_MIN][3:0];
            next_rd_data[`RTCC_TIME_ST] = pair_value[P_SEC][6:4];
            next_rd_data[`RTCC_TIME_SU] = pair_value[P_SEC][3:0];
            next_date_hold = date_now;
            next_hold_valid = 1'b1;
         end else if (hit(addr, `RTCC_OFS_DATE)) begin
            next_date_hold = hold_valid ? date_hold : date_now;
            next_rd_data[`RTCC_DATE_YT] = next_date_hold.year[7:4];
            next_rd_data[`RTCC_DATE_YU] = next_date_hold.year[3:0];
            next_rd_data[`RTCC_DATE_WD] = next_date_hold.weekday;
            next_rd_data[`RTCC_DATE_MT] = next_date_hold.month[4];
            next_rd_data[`RTCC_DATE_MU] = next_date_hold.month[3:0];
            next_rd_data[`RTCC_DATE_DT] = next_date_hold.day[5:4];
            next_rd_data[`RTCC_DATE_DU] = next_date_hold.day[3:0];
            next_hold_valid = 1'b0;
         end else if (hit(addr, `RTCC_OFS_CTRL)) begin
            next_rd_data[`RTCC_CTRL_CALIBRATION_OUTPUT_ENABLE] = ctrl.calibration_output_enable;
            next_rd_data[`RTCC_CTRL_SRC] = ctrl.event_output_source;
            next_rd_data[`RTCC_CTRL_POL] = ctrl.event_output_polarity;
            next_rd_data[`RTCC_CTRL_RATE] = ctrl.calibration_rate_select;
            next_rd_data[`RTCC_CTRL_DST] = ctrl.daylight_saving_flag;
         end else if (hit(addr, `RTCC_OFS_IRQ_STATUS)) begin
            next_rd_data[`RTCC_IRQ_W-1:0] = irq_status;
         end else if (hit(addr, `RTCC_OFS_IRQ_MASK)) begin
            next_rd_data[`RTCC_IRQ_W-1:0] = irq_mask;
         end else if (hit(addr, `RTCC_OFS_CONFIG)) begin
            next_rd_data[`RTCC_CFG_12H] = twelve_hour;
         end
      end
      if (wr_time || wr_date) begin
         next_hold_valid = 1'b0;
      end
      next_calibration_out = ctrl.calibration_output_enable &&
         (ctrl.calibration_rate_select ? spre_cnt[`RTCC_SPRE_MSB] : apre_cnt[`RTCC_APRE_MSB]);
      case (ctrl.event_output_source)
         RTCC_SRC_ALARM_A: source_active = events.alarm_a;
         RTCC_SRC_ALARM_B: source_active = events.alarm_b;
         RTCC_SRC_WAKEUP: source_active = events.wakeup;
         default: source_active = 1'b0;
      endcase
      next_event_out = source_active ^ ctrl.event_output_polarity;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         date_hold <= '0;
         hold_valid <= 1'b0;
         rd_data <= '0;
         calibration_out <= 1'b0;
         event_out <= 1'b0;
      end else begin
         date_hold <= next_date_hold;
         hold_valid <= next_hold_valid;
         rd_data <= next_rd_data;
         calibration_out <= next_calibration_out;
         event_out <= next_event_out;
      end
   end
endmodule
`default_nettype wire

// file: sim/rtcc_assertions.sv
// port checker of the calendar block: reads, event and calibration outputs
// assumes binding to rtcc_top, one ref_clk domain, synchronous rst_n
`include "rtcc_map.svh"
`default_nettype none
module rtcc_assertions
   import rtcc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [`RTCC_ADDR_W-1:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [31:0] rd_data,
   input wire logic rtc_kernel_clock,
   input wire rtcc_event_type events,
   input wire logic calibration_out,
   input wire logic event_out,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // copy of control bits 23:18 and the event level they select
   logic [5:0] ctrl_sh;
   logic [5:0] next_ctrl_sh;
   logic exp_ev;
   always_comb begin
      next_ctrl_sh = ctrl_sh;
      if (wr_en && addr == 8'h08) begin
         next_ctrl_sh = wr_data[23:18];
      end
      case (ctrl_sh[4:3])
         2'h1: exp_ev = events.alarm_a ^ ctrl_sh[2];
         2'h2: exp_ev = events.alarm_b ^ ctrl_sh[2];
         2'h3: exp_ev = events.wakeup ^ ctrl_sh[2];
         default: exp_ev = ctrl_sh[2];
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_sh <= 6'h00;
      end else begin
         ctrl_sh <= next_ctrl_sh;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_idle; !$past(rd_en) |-> rd_data == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("read data not zero when idle");
   property p_time_resv;
      rd_en && addr == 8'h00 |=> rd_data[31:23] == 9'h0 && !rd_data[15] && !rd_data[7];
   endproperty
   a_time_resv: assert property (p_time_resv) else $error("time reserved bits set");
   property p_time_dig;
      rd_en && addr == 8'h00 |=> rd_data[6:4] <= 3'h5 && rd_data[3:0] <= 4'h9
         && rd_data[14:12] <= 3'h5 && rd_data[11:8] <= 4'h9;
   endproperty
   a_time_dig: assert property (p_time_dig) else $error("time digits out of range");
   property p_hour;
      rd_en && addr == 8'h00 |=> rd_data[21:20] <= 2'h2 && rd_data[19:16] <= 4'h9;
   endproperty
   a_hour: assert property (p_hour) else $error("hour digits out of range");
   property p_date;
      rd_en && addr == 8'h04 |=> rd_data[31:24] == 8'h00 && rd_data[7:6] == 2'h0
         && rd_data[15:13] != 3'h0;
   endproperty
   a_date: assert property (p_date) else $error("date reserved or weekday bad");
   property p_ctrl;
      rd_en && addr == 8'h08 |=> rd_data == {8'h00, $past(ctrl_sh), 18'h0};
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control read mismatch");
   property p_event; event_out == $past(exp_ev); endproperty
   a_event: assert property (p_event) else $error("event output wrong");
   property p_cal; !$past(ctrl_sh[5]) |-> !calibration_out; endproperty
   a_cal: assert property (p_cal) else $error("calibration output while disabled");
   property p_unmap;
      rd_en && (addr[1:0] != 2'h0 || addr > 8'h14) |=> rd_data == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
bind rtcc_top rtcc_assertions u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
   .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
   .rtc_kernel_clock(rtc_kernel_clock), .events(events),
   .calibration_out(calibration_out), .event_out(event_out), .irq(irq));
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench of the calendar block
// assumes rtcc_top with its checker bound to it
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import rtcc_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} rtcc_row_type;
   rtcc_row_type rows [8] = '{'{8'h00, 32'h00123456, 32'h00123456},
      '{8'h00, 32'hFFC1D9D9, 32'h00415959}, '{8'h04, 32'hFF99F2F1, 32'h0099F231},
      '{8'h04, 32'h00242101, 32'h00242101}, '{8'h08, 32'hFFFC0000, 32'h00FC0000},
      '{8'h08, 32'hFF000000, 32'h00000000}, '{8'h18, 32'hFFFFFFFF, 32'h00000000},
      '{8'h10, 32'h00000007, 32'h00000007}};
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wr_data = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic kclk = 1'b0;
   rtcc_event_type events = '0;
   logic [31:0] rd_data;
   logic cal_out;
   logic ev_out;
   logic irq;
   logic [31:0] d;
   logic c;
   int bad_count = 0;
   int n_tests = 0;
   int toggles;
   rtcc_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rtc_kernel_clock(kclk),
      .events(events), .calibration_out(cal_out), .event_out(ev_out), .irq(irq));
   always #5 ref_clk = ~ref_clk;
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      d = rd_data;
      chk(n, e, d);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #900000;
      bad_count++;
      end_sim();
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      rchk("time reset", 8'h00, 32'h0);
      rchk("date reset", 8'h04, 32'h00002101);
      rchk("ctrl reset", 8'h08, 32'h0);
      $display("test reset done");
      wr(8'h00, 32'h00235959);
      wr(8'h04, 32'h0099F231);
      wr(8'h10, 32'h00000001);
      wr(8'h08, 32'h00800000);
      toggles = 0;
      c = cal_out;
      for (int i = 0; i < 33000 && irq !== 1'b1; i++) begin
         @(posedge ref_clk);
         kclk <= 1'b1;
         @(posedge ref_clk);
         kclk <= 1'b0;
         #1;
         if (cal_out !== c) toggles++;
         c = cal_out;
      end
      chk("tick irq", 32'h1, 32'(irq));
      rchk("time rollover", 8'h00, 32'h0);
      rchk("date rollover", 8'h04, 32'h00002101);
      chk("cal toggles", 32'h1, 32'(toggles >= 510 && toggles <= 514));
      wr(8'h0C, 32'h00000007);
      wr(8'h08, 32'h0);
      $display("test tick done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rchk("table read", rows[i].a, rows[i].e);
      end
      $display("test table done");
      wr(8'h10, 32'h0);
      wr(8'h04, 32'h00370515);
      rchk("weekday kept", 8'h04, 32'h00372515);
      wr(8'h00, 32'h00095030);
      wr(8'h08, 32'h00010000);
      rchk("plus hour", 8'h00, 32'h00105030);
      wr(8'h08, 32'h00020000);
      rchk("minus hour", 8'h00, 32'h00095030);
      wr(8'h00, 32'h00005030);
      wr(8'h08, 32'h00020000);
      rchk("minus at zero", 8'h00, 32'h00005030);
      wr(8'h04, 32'h00242101);
      wr(8'h00, 32'h00231000);
      wr(8'h08, 32'h00010000);
      rchk("plus midnight", 8'h00, 32'h00001000);
      rchk("plus date", 8'h04, 32'h00244102);
      wr(8'h14, 32'h00000001);
      rchk("twelve mode", 8'h14, 32'h00000001);
      wr(8'h00, 32'h00511000);
      wr(8'h08, 32'h00010000);
      rchk("twelve plus", 8'h00, 32'h00121000);
      rchk("twelve date", 8'h04, 32'h00246103);
      wr(8'h08, 32'h00020000);
      rchk("twelve minus", 8'h00, 32'h00511000);
      wr(8'h14, 32'h00000000);
      $display("test adjust done");
      rchk("status", 8'h0C, 32'h00000006);
      chk("adjust status", 32'h1, 32'(d[2]));
      chk("irq masked", 32'h0, 32'(irq));
      wr(8'h10, 32'h00000004);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("irq raised", 32'h1, 32'(irq));
      wr(8'h0C, 32'h00000007);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("irq cleared", 32'h0, 32'(irq));
      rchk("status cleared", 8'h0C, 32'h0);
      $display("test irq done");
      for (int s = 0; s < 4; s++) begin
         for (int p = 0; p < 2; p++) begin
            for (int e = 0; e < 3; e++) begin
               wr(8'h08, {9'h000, 2'(s), 1'(p), 20'h00000});
               events <= rtcc_event_type'(3'(1 << e));
               repeat (2) @(posedge ref_clk);
               #1;
               chk("event out", 32'(p[0] ^ (s != 0 && e == 3 - s)), 32'(ev_out));
            end
         end
      end
      $display("test events done");
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      rchk("ctrl rereset", 8'h08, 32'h0);
      rchk("time rereset", 8'h00, 32'h0);
      $display("test second reset done");
      end_sim();
   end
endmodule
`default_nettype wire
